// file: hw/fga_top.sv
// fast gate-a20 and soft cpu reset logic snooping keyboard port writes
// assumes a one-cycle i/o strobe on clk; smm and check pin are async
//
// How it works
// - d1h to 064h then 02h to 060h sets keyboard gate at once.
// - in full mode outside smm, keyboard chip select is held off for both writes.
// - write strobe and data still go out on both data buses.
// - system_control_port holds gate bit 1 and reset bit 0, rest ignored.
// - mode 01 passes chip select but keeps snooping for mask and reset.
// - mode 10 stops snooping; 060h and 064h writes no longer drive mask and reset.
// - mode 11 adds check pin as keyboard reset input, ored into reset.
// - every write to 064h is copied into a readable shadow register.
// - mask output forced high in smm, restored on leaving smm.
// - i/o writes to both gate controls are blocked during smm; the readback toggle is not.
// - system_control_port reads answer at any time, smm included.
// - in smm the keyboard gate is not returned on 060h reads.
// - readback bit shows last keyboard-port gate setting always.
// - writing 1 to the readback bit flips the gate; 0 does nothing.
// - mask inactive high when either gate bit is 1, active when both 0 outside smm.
// - after d0h to 064h, 060h read returns gate and reset in bits 1:0.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "fga_defs.svh"

module fga_top #(
  parameter int KRST_CYC = `FGA_KRST_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host i/o bus snoop
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rdata_oe,
  // forwarded write cycle
  output logic fwd_io_wr,
  output logic [7:0] system_data_bus,
  output logic [7:0] peripheral_data_bus,
  // keyboard controller and cpu pins
  output logic kbd_ctrl_chip_select_n,
  output logic addr_bit20_mask_out_n,
  output logic soft_cpu_reset_out,
  output logic isa_nmi_check_n,
  input wire logic system_mgmt_mode,
  input wire logic isa_channel_check_in_n,
  // wishbone config slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int KRW = $clog2(KRST_CYC + 1);

  fga_pkg::fga_state_t st_q;
  fga_pkg::fga_mode_t fast_mode;
  logic gate_toggle;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic smm_s;
  logic chk_n_s;
  logic [7:0] shadow_q;
  logic gate_kbd_q;
  logic [1:0] scp_q;
  logic [KRW-1:0] krst_cnt_q;
  logic snoop_en;
  logic wr_cmd;
  logic wr_data;
  logic wr_scp;
  logic rd_data;
  logic rd_scp;
  logic kbd_acc;
  logic fast_wr;
  logic kbd_rst_in;

  // two-flop synchronisers for the asynchronous pins
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        sync1_q[i] <= (i == 1) ? 1'b1 : 1'b0;
        sync2_q[i] <= (i == 1) ? 1'b1 : 1'b0;
      end else begin
        sync1_q[i] <= (i == 1) ? isa_channel_check_in_n : system_mgmt_mode;
        sync2_q[i] <= sync1_q[i];
      end
    end
  end
  assign smm_s = sync2_q[0];
  assign chk_n_s = sync2_q[1];

  assign snoop_en = !fast_mode[1];
  assign wr_cmd = io_wr && io_addr == `FGA_PORT_CMD;
  assign wr_data = io_wr && io_addr == `FGA_PORT_DATA;
  assign wr_scp = io_wr && io_addr == `FGA_PORT_SCP && !smm_s;
  assign rd_data = io_rd && io_addr == `FGA_PORT_DATA;
  assign rd_scp = io_rd && io_addr == `FGA_PORT_SCP;
  assign kbd_acc = (io_wr || io_rd) &&
                   (io_addr == `FGA_PORT_CMD || io_addr == `FGA_PORT_DATA);
  assign fast_wr = wr_data && st_q == fga_pkg::FGA_ST_GATE && snoop_en &&
                   !smm_s;
  assign kbd_rst_in = fast_mode == fga_pkg::FGA_MODE_KBC_RST && !chk_n_s;

  fga_wb_regs u_regs (
    .clk(clk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .shadow(shadow_q),
    .gate_kbd(gate_kbd_q),
    .fast_mode(fast_mode),
    .gate_toggle(gate_toggle)
  );

  // shadow of every command port write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow_q <= `FGA_RST_SHD;
    end else if (wr_cmd) begin
      shadow_q <= io_wdata;
    end
  end

  // command sequence tracker
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= fga_pkg::FGA_ST_IDLE;
    end else if (wr_cmd) begin
      if (io_wdata == `FGA_CMD_GATE) begin
        st_q <= fga_pkg::FGA_ST_GATE;
      end else if (io_wdata == `FGA_CMD_STAT) begin
        st_q <= fga_pkg::FGA_ST_STAT;
      end else begin
        st_q <= fga_pkg::FGA_ST_IDLE;
      end
    end else if (wr_data || (rd_data && !smm_s)) begin
      st_q <= fga_pkg::FGA_ST_IDLE;
    end
  end

  // keyboard-port gate; a data write beats a toggle in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate_kbd_q <= 1'b0;
    end else if (fast_wr) begin
      gate_kbd_q <= io_wdata[1];
    end else if (gate_toggle) begin
      gate_kbd_q <= !gate_kbd_q;
    end
  end

  // system control port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scp_q <= `FGA_RST_SCP;
    end else if (wr_scp) begin
      scp_q <= io_wdata[1:0];
    end
  end

  // reset pulse from the keyboard reset command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      krst_cnt_q <= '0;
    end else if (wr_cmd && io_wdata == `FGA_CMD_RST && snoop_en &&
                 !smm_s) begin
      krst_cnt_q <= KRW'(KRST_CYC);
    end else if (krst_cnt_q != '0) begin
      krst_cnt_q <= krst_cnt_q - KRW'(1);
    end
  end

  // cpu pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_bit20_mask_out_n <= 1'b0;
      soft_cpu_reset_out <= 1'b0;
      isa_nmi_check_n <= 1'b1;
    end else begin
      addr_bit20_mask_out_n <= smm_s || gate_kbd_q ||
                               scp_q[`FGA_SCP_GATE];
      soft_cpu_reset_out <= scp_q[`FGA_SCP_RST] || krst_cnt_q != '0 ||
                            kbd_rst_in;
      isa_nmi_check_n <= (fast_mode == fga_pkg::FGA_MODE_KBC_RST) ||
                         chk_n_s;
    end
  end

  // keyboard chip select, held off for intercepted cycles in full mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kbd_ctrl_chip_select_n <= 1'b1;
    end else if (kbd_acc) begin
      if (fast_mode == fga_pkg::FGA_MODE_FULL &&
          ((wr_cmd && io_wdata == `FGA_CMD_GATE) || fast_wr ||
           (rd_data && st_q == fga_pkg::FGA_ST_STAT && !smm_s))) begin
        kbd_ctrl_chip_select_n <= 1'b1;
      end else begin
        kbd_ctrl_chip_select_n <= 1'b0;
      end
    end else begin
      kbd_ctrl_chip_select_n <= 1'b1;
    end
  end

  // write cycle always forwarded to both data buses
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwd_io_wr <= 1'b0;
      system_data_bus <= 8'h00;
      peripheral_data_bus <= 8'h00;
    end else begin
      fwd_io_wr <= io_wr;
      if (io_wr) begin
        system_data_bus <= io_wdata;
        peripheral_data_bus <= io_wdata;
      end
    end
  end

  // read answers from the block
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
      io_rdata_oe <= 1'b0;
    end else if (rd_scp) begin
      io_rdata <= {6'h00, scp_q};
      io_rdata_oe <= 1'b1;
    end else if (rd_data && st_q == fga_pkg::FGA_ST_STAT && !smm_s) begin
      io_rdata <= {6'h00, gate_kbd_q, soft_cpu_reset_out};
      io_rdata_oe <= 1'b1;
    end else begin
      io_rdata <= 8'h00;
      io_rdata_oe <= 1'b0;
    end
  end

  AST_FAST_GATE: assert property (@(posedge clk) disable iff (!nrst)
    fast_wr && io_wdata[1] && !gate_toggle |-> ##2 addr_bit20_mask_out_n)
    else $error("fast gate write did not lift the mask");
  AST_CS_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode == fga_pkg::FGA_MODE_FULL && wr_cmd &&
    io_wdata == `FGA_CMD_GATE |=> kbd_ctrl_chip_select_n)
    else $error("chip select not held off on gate command");
  AST_FWD: assert property (@(posedge clk) disable iff (!nrst)
    io_wr |=> fwd_io_wr && system_data_bus == $past(io_wdata) &&
    peripheral_data_bus == $past(io_wdata))
    else $error("write cycle not forwarded");
  AST_SCP_WR: assert property (@(posedge clk) disable iff (!nrst)
    wr_scp |=> scp_q == $past(io_wdata[1:0]))
    else $error("system control port write lost");
  AST_CS_PASS: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode != fga_pkg::FGA_MODE_FULL && kbd_acc
    |=> !kbd_ctrl_chip_select_n)
    else $error("chip select not passed");
  AST_NO_SNOOP: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode[1] && wr_data && !gate_toggle |=> $stable(gate_kbd_q))
    else $error("snoop active while disabled");
  AST_KRST: assert property (@(posedge clk) disable iff (!nrst)
    kbd_rst_in |=> soft_cpu_reset_out)
    else $error("keyboard reset input not passed to reset");
  AST_SMM_MASK: assert property (@(posedge clk) disable iff (!nrst)
    smm_s |=> addr_bit20_mask_out_n)
    else $error("mask not forced high in smm");
  AST_SMM_BLOCK: assert property (@(posedge clk) disable iff (!nrst)
    smm_s && io_wr |=> $stable(scp_q) && (gate_toggle ||
    $past(gate_toggle) || $stable(gate_kbd_q)))
    else $error("gate control written in smm");
  AST_SCP_RD: assert property (@(posedge clk) disable iff (!nrst)
    rd_scp |=> io_rdata_oe && io_rdata == {6'h00, $past(scp_q)})
    else $error("system control port read failed");
  AST_SMM_RD: assert property (@(posedge clk) disable iff (!nrst)
    smm_s && rd_data && !rd_scp |=> !io_rdata_oe)
    else $error("keyboard gate returned in smm");
  AST_TOGGLE: assert property (@(posedge clk) disable iff (!nrst)
    gate_toggle && !fast_wr |=> gate_kbd_q != $past(gate_kbd_q))
    else $error("readback toggle had no effect");
  AST_CANCEL: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmd && io_wdata != `FGA_CMD_GATE |=> st_q != fga_pkg::FGA_ST_GATE)
    else $error("sequence not cancelled");

  // pin and register checks
  AST_SHADOW: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmd |=> shadow_q == $past(io_wdata))
    else $error("command write not shadowed");
  AST_MASK_LOW: assert property (@(posedge clk) disable iff (!nrst)
    !smm_s && !gate_kbd_q && !scp_q[`FGA_SCP_GATE]
    |=> !addr_bit20_mask_out_n)
    else $error("mask not active with both gate bits clear");
  AST_MASK_HIGH: assert property (@(posedge clk) disable iff (!nrst)
    gate_kbd_q || scp_q[`FGA_SCP_GATE] |=> addr_bit20_mask_out_n)
    else $error("mask active with a gate bit set");
  AST_RST_SCP: assert property (@(posedge clk) disable iff (!nrst)
    scp_q[`FGA_SCP_RST] |=> soft_cpu_reset_out)
    else $error("control port reset bit not driving reset");
  AST_FAST_RST: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmd && io_wdata == `FGA_CMD_RST && snoop_en && !smm_s
    |-> ##2 soft_cpu_reset_out)
    else $error("keyboard reset command gave no reset pulse");
  AST_NO_KRST: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode[1] && krst_cnt_q == '0 |=> krst_cnt_q == '0)
    else $error("keyboard reset command honoured while not snooping");
  AST_NMI: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode == fga_pkg::FGA_MODE_KBC_RST |=> isa_nmi_check_n)
    else $error("check pin still raises nmi in keyboard reset mode");
  AST_STATUS: assert property (@(posedge clk) disable iff (!nrst)
    rd_data && st_q == fga_pkg::FGA_ST_STAT && !smm_s
    |=> io_rdata_oe && io_rdata[1] == $past(gate_kbd_q))
    else $error("status read did not return the gate bit");
  AST_RDBACK: assert property (@(posedge clk) disable iff (!nrst)
    wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i &&
    wb_adr_i == `FGA_ADR_FC2
    |-> wb_dat_o[`FGA_FC2_GATE] == $past(gate_kbd_q))
    else $error("readback bit differs from keyboard gate");
  AST_CS_DATA: assert property (@(posedge clk) disable iff (!nrst)
    fast_mode == fga_pkg::FGA_MODE_FULL && fast_wr
    |=> kbd_ctrl_chip_select_n)
    else $error("chip select not held off on fast data write");
  AST_SEQ_END: assert property (@(posedge clk) disable iff (!nrst)
    wr_data |=> st_q == fga_pkg::FGA_ST_IDLE)
    else $error("sequence still pending after data write");
  AST_FWD_OFF: assert property (@(posedge clk) disable iff (!nrst)
    !io_wr |=> !fwd_io_wr)
    else $error("write strobe forwarded without a write");

  COV_FAST: cover property (@(posedge clk) disable iff (!nrst)
    wr_cmd && io_wdata == `FGA_CMD_GATE ##[1:20] fast_wr);
  COV_SMM: cover property (@(posedge clk) disable iff (!nrst)
    smm_s && gate_toggle);
  COV_KRST: cover property (@(posedge clk) disable iff (!nrst)
    kbd_rst_in);
  COV_STAT: cover property (@(posedge clk) disable iff (!nrst)
    rd_data && st_q == fga_pkg::FGA_ST_STAT && !smm_s);
  COV_FAST_RST: cover property (@(posedge clk) disable iff (!nrst)
    krst_cnt_q == KRW'(KRST_CYC));
endmodule : fga_top

// file: hw/fga_defs.svh
// constants for the fast gate-a20 and soft reset block
// included by the package user files; definitions only
`ifndef FGA_DEFS_SVH
`define FGA_DEFS_SVH

// keyboard controller and system control i/o ports
`define FGA_PORT_DATA 16'h0060
`define FGA_PORT_CMD 16'h0064
`define FGA_PORT_SCP 16'h0092

// keyboard controller commands
`define FGA_CMD_GATE 8'hd1
`define FGA_CMD_STAT 8'hd0
`define FGA_CMD_RST 8'hfe

// config register indices; byte address is index times four
`define FGA_IDX_FLC 8'h79
`define FGA_IDX_SHD 8'h9f
`define FGA_IDX_FC2 8'ha1
`define FGA_ADR_FLC {`FGA_IDX_FLC, 2'b00}
`define FGA_ADR_SHD {`FGA_IDX_SHD, 2'b00}
`define FGA_ADR_FC2 {`FGA_IDX_FC2, 2'b00}

// field positions
`define FGA_FLC_MODE_LO 0
`define FGA_FC2_GATE 7
`define FGA_SCP_GATE 1
`define FGA_SCP_RST 0

// reset values
`define FGA_RST_FLC 2'h0
`define FGA_RST_SHD 8'h00
`define FGA_RST_SCP 2'h0

// timing: keyboard-path reset pulse length
`define FGA_CLK_NS 20
`define FGA_KRST_NS 320
`define FGA_KRST_CYC ((`FGA_KRST_NS + `FGA_CLK_NS - 1) / `FGA_CLK_NS)

`endif

// file: hw/fga_pkg.sv
// types for the fast gate-a20 and soft reset block
// no dependencies
package fga_pkg;
  // gray-coded snoop sequence states
  typedef enum logic [1:0] {
    FGA_ST_IDLE = 2'b00,
    FGA_ST_GATE = 2'b01,
    FGA_ST_STAT = 2'b11
  } fga_state_t;

  // inhibit level of the fast logic
  typedef enum logic [1:0] {
    FGA_MODE_FULL = 2'b00,
    FGA_MODE_PASS_CS = 2'b01,
    FGA_MODE_NO_SNOOP = 2'b10,
    FGA_MODE_KBC_RST = 2'b11
  } fga_mode_t;
endpackage : fga_pkg

// file: hw/fga_wb_regs.sv
// classic wishbone slave holding the chipset config registers
// assumes a single-clock master; one aligned 32-bit word per register
`timescale 1ns/1ps
`include "fga_defs.svh"

module fga_wb_regs (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // block state
  input wire logic [7:0] shadow,
  input wire logic gate_kbd,
  output fga_pkg::fga_mode_t fast_mode,
  output logic gate_toggle
);
  logic req;
  logic wr_lane0;
  logic [1:0] mode_q;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
  assign fast_mode = fga_pkg::fga_mode_t'(mode_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= `FGA_RST_FLC;
    end else if (wr_lane0 && wb_adr_i == `FGA_ADR_FLC) begin
      mode_q <= wb_dat_i[`FGA_FLC_MODE_LO +: 2];
    end
  end

  // write of 1 to the readback bit flips the keyboard gate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate_toggle <= 1'b0;
    end else begin
      gate_toggle <= wr_lane0 && wb_adr_i == `FGA_ADR_FC2 &&
                     wb_dat_i[`FGA_FC2_GATE];
    end
  end

  // unmapped addresses answer with zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      if (wb_adr_i == `FGA_ADR_FLC) begin
        wb_dat_o <= {30'h0, mode_q};
      end else if (wb_adr_i == `FGA_ADR_SHD) begin
        wb_dat_o <= {24'h0, shadow};
      end else if (wb_adr_i == `FGA_ADR_FC2) begin
        wb_dat_o <= {24'h0, gate_kbd, 7'h0};
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end
endmodule : fga_wb_regs

// file: verif/fga_kbc_model.sv
// keyboard controller stand-in at the far side of the fast gate block
// counts chip select pulses; drives its reset line onto the check pin
`timescale 1ns/1ps
module fga_kbc_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins shared with the block
  input wire logic kbd_ctrl_chip_select_n,
  input wire logic soft_cpu_reset_out,
  output logic isa_channel_check_in_n,
  // bench side
  input wire logic rst_req,
  output logic [7:0] cs_count,
  output logic sys_reset
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_count <= 8'h00;
    end else if (!kbd_ctrl_chip_select_n) begin
      cs_count <= cs_count + 8'h01;
    end
  end

  // controller reset output, active low
  assign isa_channel_check_in_n = !rst_req;
  // board-level merge of both reset sources
  assign sys_reset = soft_cpu_reset_out | rst_req;
endmodule : fga_kbc_model

// file: verif/test_fga_top.sv
// self-checking bench for the fast gate-a20 and soft reset block
// host i/o strobes and wishbone come from tasks; kbc model on far side
`timescale 1ns/1ps
`include "fga_defs.svh"
module test_fga_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata, system_data_bus, peripheral_data_bus, cs_count;
  logic io_rdata_oe, fwd_io_wr, kbd_ctrl_chip_select_n, isa_nmi_check_n;
  logic addr_bit20_mask_out_n, soft_cpu_reset_out, sys_reset;
  logic system_mgmt_mode = 1'b0;
  logic kbc_rst_req = 1'b0;
  logic isa_channel_check_in_n;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o;
  logic [7:0] n;
  int num_errors = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  fga_top #(.KRST_CYC(2)) uut (.clk, .nrst, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .io_rdata_oe, .fwd_io_wr, .system_data_bus,
    .peripheral_data_bus, .kbd_ctrl_chip_select_n, .addr_bit20_mask_out_n,
    .soft_cpu_reset_out, .isa_nmi_check_n, .system_mgmt_mode,
    .isa_channel_check_in_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

  fga_kbc_model kbc (.clk, .nrst, .kbd_ctrl_chip_select_n,
    .soft_cpu_reset_out, .isa_channel_check_in_n, .rst_req(kbc_rst_req),
    .cs_count, .sys_reset);

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // one-cycle i/o strobe; outputs settled on return
  task automatic io_op(input logic [15:0] a, input logic [7:0] d,
                       input logic r);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= !r;
    io_rd <= r;
    @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask : io_op

  task automatic wb(input logic we, input logic [9:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      give_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic t_reset();
    chk("mask_n", addr_bit20_mask_out_n, 0);
    chk("srst", soft_cpu_reset_out, 0);
    wb(0, `FGA_ADR_FLC, 0);
    chk("flc", rd, 0);
    wb(1, `FGA_ADR_SHD, 32'h55);
    wb(0, `FGA_ADR_SHD, 0);
    chk("shadow", rd, 0);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 0);
    wb(0, 10'h004, 0);
    chk("unmapped", rd, 0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_fast();
    n = cs_count;
    io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
    chk("fwd", fwd_io_wr, 1);
    chk("sd", system_data_bus, 8'hd1);
    io_op(`FGA_PORT_DATA, 8'h02, 0);
    chk("xd", peripheral_data_bus, 8'h02);
    chk("fwd", fwd_io_wr, 1);
    cyc(1);
    chk("mask_n", addr_bit20_mask_out_n, 1);
    chk("cs count", cs_count, n);
    wb(0, `FGA_ADR_SHD, 0);
    chk("shadow", rd, 8'hd1);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 8'h80);
    io_op(`FGA_PORT_CMD, `FGA_CMD_STAT, 0);
    io_op(`FGA_PORT_DATA, 0, 1);
    chk("oe", io_rdata_oe, 1);
    chk("status", io_rdata, 8'h02);
    io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
    io_op(`FGA_PORT_DATA, 8'h00, 0);
    cyc(1);
    chk("mask_n", addr_bit20_mask_out_n, 0);
    n = cs_count;
    io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
    io_op(`FGA_PORT_CMD, 8'haa, 0);
    io_op(`FGA_PORT_DATA, 8'h02, 0);
    cyc(2);
    chk("mask_n", addr_bit20_mask_out_n, 0);
    chk("cs count", cs_count, n + 8'h02);
    $display("fast sequence test done");
  endtask : t_fast

  task automatic t_scp();
    io_op(`FGA_PORT_SCP, 8'hfe, 0);
    cyc(1);
    chk("mask_n", addr_bit20_mask_out_n, 1);
    chk("srst", soft_cpu_reset_out, 0);
    io_op(`FGA_PORT_SCP, 0, 1);
    chk("scp", io_rdata, 8'h02);
    io_op(`FGA_PORT_SCP, 8'h01, 0);
    cyc(1);
    chk("srst", soft_cpu_reset_out, 1);
    io_op(`FGA_PORT_SCP, 8'h00, 0);
    cyc(1);
    chk("srst", soft_cpu_reset_out, 0);
    chk("mask_n", addr_bit20_mask_out_n, 0);
    // keyboard reset command: pulse of two cycles with KRST_CYC of 2
    io_op(`FGA_PORT_CMD, `FGA_CMD_RST, 0);
    chk("srst", soft_cpu_reset_out, 0);
    cyc(1);
    chk("srst", soft_cpu_reset_out, 1);
    cyc(1);
    chk("srst", soft_cpu_reset_out, 1);
    cyc(1);
    chk("srst", soft_cpu_reset_out, 0);
    $display("control port test done");
  endtask : t_scp

  task automatic t_modes();
    for (int m = 1; m < 4; m++) begin
      wb(1, `FGA_ADR_FLC, m);
      n = cs_count;
      io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
      io_op(`FGA_PORT_DATA, 8'h02, 0);
      cyc(2);
      chk("cs count", cs_count, n + 8'h02);
      chk("mask_n", addr_bit20_mask_out_n, m == 1);
      io_op(`FGA_PORT_CMD, `FGA_CMD_RST, 0);
      cyc(1);
      chk("srst", soft_cpu_reset_out, m == 1);
      io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
      io_op(`FGA_PORT_DATA, 8'h00, 0);
      io_op(`FGA_PORT_SCP, 8'h02, 0);
      cyc(1);
      chk("mask_n", addr_bit20_mask_out_n, 1);
      io_op(`FGA_PORT_SCP, 8'h00, 0);
    end
    @(posedge clk);
    kbc_rst_req <= 1'b1;
    cyc(5);
    chk("srst", soft_cpu_reset_out, 1);
    chk("nmi_n", isa_nmi_check_n, 1);
    chk("sys_reset", sys_reset, 1);
    @(posedge clk);
    kbc_rst_req <= 1'b0;
    cyc(5);
    chk("srst", soft_cpu_reset_out, 0);
    chk("sys_reset", sys_reset, 0);
    wb(1, `FGA_ADR_FLC, 0);
    // check pin in full mode is an nmi source, not a reset
    @(posedge clk);
    kbc_rst_req <= 1'b1;
    cyc(5);
    chk("nmi_n", isa_nmi_check_n, 0);
    chk("srst", soft_cpu_reset_out, 0);
    @(posedge clk);
    kbc_rst_req <= 1'b0;
    cyc(5);
    chk("nmi_n", isa_nmi_check_n, 1);
    $display("inhibit mode test done");
  endtask : t_modes

  task automatic t_smm();
    @(posedge clk);
    system_mgmt_mode <= 1'b1;
    cyc(4);
    chk("mask_n", addr_bit20_mask_out_n, 1);
    io_op(`FGA_PORT_SCP, 8'h02, 0);
    io_op(`FGA_PORT_CMD, `FGA_CMD_GATE, 0);
    io_op(`FGA_PORT_DATA, 8'h02, 0);
    io_op(`FGA_PORT_SCP, 0, 1);
    chk("oe", io_rdata_oe, 1);
    chk("scp", io_rdata, 0);
    io_op(`FGA_PORT_CMD, `FGA_CMD_STAT, 0);
    io_op(`FGA_PORT_DATA, 0, 1);
    chk("oe", io_rdata_oe, 0);
    // readback and toggle still work inside smm
    wb(1, `FGA_ADR_FC2, 8'h80);
    cyc(3);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 8'h80);
    chk("mask_n", addr_bit20_mask_out_n, 1);
    wb(1, `FGA_ADR_FC2, 8'h80);
    cyc(3);
    @(posedge clk);
    system_mgmt_mode <= 1'b0;
    cyc(4);
    chk("mask_n", addr_bit20_mask_out_n, 0);
    // write 0 and read, then toggle and read back, twice
    wb(1, `FGA_ADR_FC2, 0);
    cyc(3);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 0);
    wb(1, `FGA_ADR_FC2, 8'h80);
    cyc(3);
    chk("mask_n", addr_bit20_mask_out_n, 1);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 8'h80);
    wb(1, `FGA_ADR_FC2, 8'h80);
    cyc(3);
    wb(0, `FGA_ADR_FC2, 0);
    chk("fc2", rd, 0);
    $display("smm test done");
  endtask : t_smm

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_fast();
    t_scp();
    t_modes();
    t_smm();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : test_fga_top
